/* File: core_host.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Host gives a count pulse plus forward or reverse level per step unless auto interlace is fitted.
// - Host issues one swap pulse per swap unless auto interlace is fitted.
// - Host sets levels before zero time, pulses strobes at zero time.
// - Host should unload or clear a location before loading it; core_host issues each load as commanded and never unloads or clears first.
module core_host (
  input  wire logic                                clk,           // 25 MHz clock
  input  wire logic                                rst_b,         // Async reset, low
  input  wire logic                                cmd_valid,     // Command request
  input  wire core_host_pkg::op_t                  cmd_op,        // Command kind
  input  wire logic [core_host_pkg::ADDR_W-1:0]    cmd_addr,      // Address for cycle
  input  wire logic [core_host_pkg::DATA_W-1:0]    cmd_data,      // Word to store
  input  wire logic                                cmd_use_addr,  // Strobe address in
  input  wire logic                                cmd_reverse,   // Count downward
  input  wire logic                                auto_interlace,// Interlace option on
  output logic                                     cmd_ready,     // Idle, may accept
  output logic                                     rsp_valid,     // Cycle finished pulse
  output logic      [core_host_pkg::DATA_W-1:0]    rsp_data,      // Word read back
  output logic      [core_host_pkg::ADDR_W-1:0]    rsp_addr,      // Address out sampled
  output logic      [core_host_pkg::ADDR_W-1:0]    addr_lines,    // Address levels
  output logic      [core_host_pkg::DATA_W-1:0]    data_lines,    // Data levels
  output logic                                     addr_strobe,   // Address strobe
  output logic                                     data_strobe,   // Data strobe
  output logic                                     load_sync,     // Load sync pulse
  output logic                                     unload_sync,   // Unload sync pulse
  output logic                                     core_store_mode_level, // Memory mode
  output logic                                     count_pulse,   // Step request
  output logic                                     fwd_level,     // Forward direction
  output logic                                     swap_pulse,    // Swap request
  output logic                                     master_clear,  // Master clear pulse
  output logic                                     auto_interlace_option, // Option level
  input  wire logic [core_host_pkg::ADDR_W-1:0]    addr_out,      // Device address out
  input  wire logic [core_host_pkg::DATA_W-1:0]    info_out       // Device data out
);
  logic                              rst_meta;
  logic                              rst_n;
  core_host_pkg::state_t             state;
  core_host_pkg::op_t                op;
  logic [core_host_pkg::CNT_W-1:0]   limit;
  logic [core_host_pkg::CNT_W-1:0]   count;
  logic                              expired;
  logic                              start;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  function automatic logic [core_host_pkg::CNT_W-1:0] cycle_len(input core_host_pkg::op_t o);
    case (o)
      core_host_pkg::op_cwrite,
      core_host_pkg::op_rrest:  cycle_len = core_host_pkg::CNT_W'(core_host_pkg::MEM_CYCLE_CYC);
      default:                  cycle_len = core_host_pkg::CNT_W'(core_host_pkg::BUF_CYCLE_CYC);
    endcase
  endfunction : cycle_len

  function automatic logic is_read(input core_host_pkg::op_t o);
    is_read = (o == core_host_pkg::op_unload) || (o == core_host_pkg::op_rrest);
  endfunction : is_read

  function automatic logic is_write(input core_host_pkg::op_t o);
    is_write = (o == core_host_pkg::op_load) || (o == core_host_pkg::op_cwrite);
  endfunction : is_write

  function automatic logic is_mem(input core_host_pkg::op_t o);
    is_mem = (o == core_host_pkg::op_cwrite) || (o == core_host_pkg::op_rrest);
  endfunction : is_mem

  assign cmd_ready = (state == core_host_pkg::st_idle);
  assign start     = (state == core_host_pkg::st_setup) && expired;

  cycle_timer u_timer (
    .clk     (clk),
    .rst_n   (rst_n),
    .start   (start || (cmd_ready && cmd_valid)),
    .limit   (limit),
    .count   (count),
    .expired (expired)
  );

  // Command kind held for the whole cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      op <= core_host_pkg::op_load;
    end else if (cmd_ready && cmd_valid) begin
      op <= cmd_op;
    end
  end

  // Timer bound: setup first, then the body less the sync and done states
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      limit <= '0;
    end else if (cmd_ready && cmd_valid) begin
      limit <= core_host_pkg::CNT_W'(core_host_pkg::SETUP_CYC);
    end else if (state == core_host_pkg::st_sync) begin
      limit <= cycle_len(op) - core_host_pkg::CNT_W'(2);
    end
  end

  // Sequencer: setup, zero-time pulse, then hold off for the device cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= core_host_pkg::st_idle;
    end else begin
      case (state)
        core_host_pkg::st_idle: begin
          if (cmd_valid) begin
            state <= core_host_pkg::st_setup;
          end
        end
        core_host_pkg::st_setup: begin
          if (expired) begin
            state <= core_host_pkg::st_sync;
          end
        end
        core_host_pkg::st_sync: begin
          state <= core_host_pkg::st_wait;
        end
        core_host_pkg::st_wait: begin
          if (expired) begin
            state <= core_host_pkg::st_done;
          end
        end
        core_host_pkg::st_done: state <= core_host_pkg::st_idle;
        default:                state <= core_host_pkg::st_idle;
      endcase
    end
  end

  // Levels settle before zero time and stay through the cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_lines            <= '0;
      data_lines            <= '0;
      core_store_mode_level <= 1'b0;
      fwd_level             <= 1'b1;
      auto_interlace_option <= 1'b0;
    end else if (cmd_ready && cmd_valid) begin
      addr_lines            <= cmd_addr;
      data_lines            <= cmd_data; // loaded words are ORed unless cleared first; core writes replace
      core_store_mode_level <= is_mem(cmd_op);
      fwd_level             <= !cmd_reverse;
      auto_interlace_option <= auto_interlace;
    end
  end

  // Zero-time pulses, one clock wide
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_strobe  <= 1'b0;
      data_strobe  <= 1'b0;
      load_sync    <= 1'b0;
      unload_sync  <= 1'b0;
      count_pulse  <= 1'b0;
      swap_pulse   <= 1'b0;
      master_clear <= 1'b0;
    end else begin
      // Select read live at zero time, so the user holds it through setup
      addr_strobe  <= start && cmd_use_addr && (op <= core_host_pkg::op_rrest);
      data_strobe  <= start && is_write(op);
      // Direction and phase flags in the device follow these syncs
      load_sync    <= start && is_write(op);
      unload_sync  <= start && is_read(op);
      count_pulse  <= start && (op == core_host_pkg::op_count) && !auto_interlace_option;
      swap_pulse   <= start && (op == core_host_pkg::op_swap) && !auto_interlace_option;
      master_clear <= start && (op == core_host_pkg::op_mclear);
    end
  end

  // Address valid 1.5 us after the sync launch edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_addr <= '0;
    end else if (state == core_host_pkg::st_wait &&
                 count == core_host_pkg::CNT_W'(core_host_pkg::ADDR_VALID_CYC - 1)) begin
      rsp_addr <= addr_out;
    end
  end

  // Read data valid at 4 us; writes leave the last word read in place
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_data <= '0;
    end else if (state == core_host_pkg::st_wait && is_read(op) &&
                 count == core_host_pkg::CNT_W'(core_host_pkg::READ_VALID_CYC - 1)) begin
      rsp_data <= info_out;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state == core_host_pkg::st_done);
    end
  end
endmodule : core_host
`default_nettype wire

/* File: core_host_pkg.sv */
package core_host_pkg;
  localparam int CLK_MHZ          = 25;
  localparam int ADDR_W           = 10;
  localparam int DATA_W           = 24;
  // Times in nanoseconds
  localparam int BUF_CYCLE_NS     = 5000;
  localparam int MEM_CYCLE_NS     = 8000;
  localparam int DRIVE_AT_NS      = 1000;
  localparam int ADDR_VALID_NS    = 1500;
  localparam int READ_VALID_NS    = 4000;
  localparam int SETUP_NS         = 80;
  localparam int BUF_CYCLE_CYC    = (BUF_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int MEM_CYCLE_CYC    = (MEM_CYCLE_NS * CLK_MHZ + 999) / 1000;
  localparam int ADDR_VALID_CYC   = (ADDR_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int READ_VALID_CYC   = (READ_VALID_NS * CLK_MHZ + 999) / 1000;
  localparam int SETUP_CYC        = (SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W            = 9;

  typedef enum logic [2:0] {
    op_load   = 3'h0,
    op_unload = 3'h1,
    op_cwrite = 3'h2,
    op_rrest  = 3'h3,
    op_count  = 3'h4,
    op_swap   = 3'h5,
    op_mclear = 3'h6
  } op_t;

  typedef enum logic [2:0] {
    st_idle  = 3'h0,
    st_setup = 3'h1,
    st_sync  = 3'h3,
    st_wait  = 3'h2,
    st_done  = 3'h6
  } state_t;
endpackage : core_host_pkg

/* File: core_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module core_host_sva (
  input wire logic               clk,                  // Clock
  input wire logic               rst_b,                // Reset
  input wire logic               cmd_valid,            // Request
  input wire core_host_pkg::op_t cmd_op,               // Kind
  input wire logic               cmd_ready,            // Idle
  input wire logic               rsp_valid,            // Done
  input wire logic               load_sync,            // Load
  input wire logic               unload_sync,          // Unload
  input wire logic               core_store_mode_level, // Memory
  input wire logic               count_pulse,          // Step
  input wire logic               swap_pulse,           // Swap
  input wire logic               auto_interlace_option // Option
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  logic acc;
  logic mem_op;
  assign acc = cmd_valid && cmd_ready;
  assign mem_op = cmd_op inside {core_host_pkg::op_cwrite, core_host_pkg::op_rrest};
  a_ready_drop: assert property (acc |=> !cmd_ready) else $error("busy");
  a_load_zero: assert property (acc && cmd_op == core_host_pkg::op_load |-> ##[3:4] load_sync)
    else $error("no load sync");
  a_unload_zero: assert property (acc && cmd_op == core_host_pkg::op_unload
    |-> ##[3:4] unload_sync) else $error("no unload sync");
  a_sync_single: assert property (load_sync |=> !load_sync) else $error("long sync");
  a_buf_len: assert property (acc && cmd_op < core_host_pkg::op_cwrite
    |-> ##[120:140] rsp_valid) else $error("buffer length");
  a_mem_len: assert property (acc && mem_op |-> ##[195:215] rsp_valid)
    else $error("memory length");
  a_ready_back: assert property (rsp_valid |-> ##[1:2] cmd_ready) else $error("stuck");
  a_mode_level: assert property (acc && cmd_op < core_host_pkg::op_count
    |=> core_store_mode_level == $past(cmd_op[1])) else $error("mode");
  a_no_auto_step: assert property (auto_interlace_option |-> !count_pulse && !swap_pulse)
    else $error("step with option");
  cover property (acc && cmd_op == core_host_pkg::op_swap);
  cover property (unload_sync && core_store_mode_level);
  cover property (load_sync);
endmodule : core_host_sva
bind core_host core_host_sva chk (.clk, .rst_b, .cmd_valid, .cmd_op, .cmd_ready,
  .rsp_valid, .load_sync, .unload_sync, .core_store_mode_level, .count_pulse,
  .swap_pulse, .auto_interlace_option);
`default_nettype wire

/* File: core_host_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module core_host_tb_top;
  logic clk = 1'b0;
  logic rst_b, cmd_valid, cmd_use_addr, cmd_reverse, auto_interlace, cmd_ready, rsp_valid;
  logic addr_strobe, data_strobe, load_sync, unload_sync, core_store_mode_level;
  logic count_pulse, fwd_level, swap_pulse, master_clear, auto_interlace_option;
  logic [9:0]  cmd_addr, rsp_addr, addr_lines, addr_out, a, sw;
  logic [23:0] cmd_data, rsp_data, data_lines, info_out, d1, d2;
  logic [31:0] seed = 32'h425e6513;
  core_host_pkg::op_t cmd_op;
  int errors = 0;
  int tests_run = 0;
  always #20 clk = ~clk;
  core_host DUT (.clk, .rst_b, .cmd_valid, .cmd_op, .cmd_addr, .cmd_data, .cmd_use_addr,
    .cmd_reverse, .auto_interlace, .cmd_ready, .rsp_valid, .rsp_data, .rsp_addr,
    .addr_lines, .data_lines, .addr_strobe, .data_strobe, .load_sync, .unload_sync,
    .core_store_mode_level, .count_pulse, .fwd_level, .swap_pulse, .master_clear,
    .auto_interlace_option, .addr_out, .info_out);
  core_store_model store (.clk, .addr_lines, .data_lines, .addr_strobe, .data_strobe,
    .load_sync, .unload_sync, .core_store_mode_level, .count_pulse, .fwd_level,
    .swap_pulse, .master_clear, .auto_interlace_option, .addr_out, .info_out);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [9:0] stepped(input logic [9:0] v, input logic rv);
    return rv ? v - 10'h1 : v + 10'h1;
  endfunction : stepped
  task automatic chk(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic stop_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : stop_test
  // Flags f: use address, reverse, interlace option
  task automatic run(input logic [2:0] op, input logic [9:0] ad, input logic [23:0] d,
                     input logic [2:0] f);
    int n = 0;
    while (cmd_ready !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    cmd_op <= core_host_pkg::op_t'(op);
    {cmd_addr, cmd_data, cmd_use_addr, cmd_reverse, auto_interlace} <= {ad, d, f};
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (rsp_valid !== 1'b1 && n < 600) begin
      @(negedge clk);
      n++;
    end
    if (n >= 600) begin
      errors++;
      stop_test();
    end
  endtask : run
  initial begin
    #4000000;
    errors++;
    stop_test();
  end
  initial begin
    rst_b = 1'b0;
    cmd_op = core_host_pkg::op_load;
    {cmd_valid, cmd_addr, cmd_data, cmd_use_addr, cmd_reverse, auto_interlace} = '0;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk);
    run(3'h6, 10'h0, 24'h0, 3'h0);
    run(3'h1, 10'h0, 24'h0, 3'h0);
    chk("clear addr", 24'(rsp_addr), 24'h0);
    sw = 10'h0;
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      a = seed[9:0];
      seed = lfsr(seed);
      d1 = seed[23:0];
      seed = lfsr(seed);
      d2 = seed[23:0];
      run(3'h0, a, d1, 3'h4);
      chk("load addr", 24'(rsp_addr), 24'(a));
      run(3'h0, a, d2, 3'h4);
      run(3'h1, a, 24'h0, 3'h4);
      chk("or data", rsp_data, d1 | d2);
      run(3'h1, a, 24'h0, 3'h4);
      chk("destroyed", rsp_data, 24'h0);
      run(3'h2, a, d1, 3'h4);
      run(3'h3, a, 24'h0, 3'h4);
      run(3'h3, a, 24'h0, 3'h4);
      chk("restored", rsp_data, d1);
      run(3'h4, 10'h0, 24'h0, {1'b0, i[0], 1'b0});
      run(3'h1, 10'h0, 24'h0, 3'h0);
      chk("step", 24'(rsp_addr), 24'(stepped(a, i[0])));
      run(3'h5, 10'h0, 24'h0, 3'h0);
      run(3'h1, 10'h0, 24'h0, 3'h0);
      chk("swap", 24'(rsp_addr), 24'(sw));
      sw = stepped(a, i[0]);
    end
    run(3'h6, 10'h0, 24'h0, 3'h1);
    run(3'h4, 10'h0, 24'h0, 3'h1);
    run(3'h1, 10'h0, 24'h0, 3'h1);
    chk("interlace start", 24'(rsp_addr), 24'h3ff);
    stop_test();
  end
endmodule : core_host_tb_top
`default_nettype wire

/* File: core_store_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_store_model (
  input  wire logic        clk,                   // Clock
  input  wire logic [9:0]  addr_lines,            // Address
  input  wire logic [23:0] data_lines,            // Data
  input  wire logic        addr_strobe,           // Strobe
  input  wire logic        data_strobe,           // Strobe
  input  wire logic        load_sync,             // Load
  input  wire logic        unload_sync,           // Unload
  input  wire logic        core_store_mode_level, // Memory
  input  wire logic        count_pulse,           // Step
  input  wire logic        fwd_level,             // Up
  input  wire logic        swap_pulse,            // Swap
  input  wire logic        master_clear,          // Clear
  input  wire logic        auto_interlace_option, // Option
  output logic      [9:0]  addr_out,              // Address
  output logic      [23:0] info_out               // Data
);
  logic [23:0] core_words [1024];
  logic [9:0]  address_holder;
  logic [9:0]  swap_holder;
  logic [23:0] data_word_register;
  logic [9:0]  ad;
  logic [23:0] dw;
  logic [9:0]  wr_addr;
  logic        write_phase_flag;
  logic        direction_flag;
  // Strobe coincides with sync, so take the live levels
  assign ad = addr_strobe ? addr_lines : address_holder;
  assign dw = data_strobe ? data_lines : data_word_register;
  assign addr_out = address_holder;
  assign info_out = data_word_register;
  always @(posedge clk) begin
    if (addr_strobe) address_holder <= addr_lines;
    if (data_strobe) data_word_register <= dw;
    // Word lands one edge after the sync, once the write phase is open
    if (load_sync) begin
      write_phase_flag <= 1'b1;
      direction_flag   <= 1'b1;
      wr_addr          <= ad;
    end
    if (unload_sync) direction_flag <= 1'b0;
    if (write_phase_flag && direction_flag) begin
      core_words[wr_addr] <= core_store_mode_level ? data_word_register :
                             core_words[wr_addr] | data_word_register;
      write_phase_flag    <= 1'b0;
    end
    if (unload_sync) begin
      data_word_register <= core_words[ad];
      if (!core_store_mode_level) core_words[ad] <= '0;
    end
    if (count_pulse) address_holder <= fwd_level ? ad + 10'h1 : ad - 10'h1;
    if (swap_pulse) begin
      address_holder <= swap_holder;
      swap_holder <= ad;
    end
    if (master_clear) begin
      for (int i = 0; i < 1024; i++) core_words[i] <= '0;
      data_word_register <= '0;
      address_holder <= auto_interlace_option ? 10'h3ff : 10'h0;
      swap_holder <= '0;
      write_phase_flag <= 1'b0;
      direction_flag <= 1'b0;
    end
  end
endmodule : core_store_model
`default_nettype wire

/* File: cycle_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module cycle_timer (
  input  wire logic                          clk,     // System clock
  input  wire logic                          rst_n,   // Synchronised reset
  input  wire logic                          start,   // Restart count at zero
  input  wire logic [core_host_pkg::CNT_W-1:0] limit, // Terminal count
  output logic      [core_host_pkg::CNT_W-1:0] count, // Cycles since start
  output logic                               expired  // Count reached limit
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else if (start) begin
      count <= '0;
    end else if (!expired) begin
      count <= count + 1'b1;
    end
  end

  assign expired = (count >= limit);
endmodule : cycle_timer
`default_nettype wire
